// [design/rmc_map.svh]
/*
  Offsets, field positions, reset values and limits for the rotate, mask
  and compare unit. Assumes inclusion by the package and the rmc_unit module.
*/
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH

// ==========================================================
// Word and field layout
`define RMC_XLEN 32
`define RMC_SHW 5
`define RMC_CNTW 6
`define RMC_IMMW 16
`define RMC_WORD_SIZE 1'h0
`define RMC_FLD_LT 2'h0
`define RMC_FLD_GT 2'h1
`define RMC_FLD_EQ 2'h2
`define RMC_FLD_SO 2'h3
`define RMC_FIRST_RESULT_FIELD 3'h0

// ==========================================================
// Reset values and limits
`define RMC_CR_RESET 32'h0
`define RMC_RESULT_RESET 32'h0
`define RMC_WORD_BITS 6'h20
`define RMC_LAST_BIT 6'h1f

`endif

// [design/rmc_pkg.sv]
/*
  Types of the rotate, mask and compare unit: operation codes,
  condition-bit functions and the request bundle.
  Assumes rmc_map.svh is on the include path.
*/
`include "rmc_map.svh"

package rmc_pkg;

  // ==========================================================
  // Operations
  typedef enum logic [3:0] {
    RMC_EXTL = 4'h0,
    RMC_EXTR = 4'h1,
    RMC_INSL = 4'h2,
    RMC_INSR = 4'h3,
    RMC_ROTLI = 4'h4,
    RMC_ROTRI = 4'h5,
    RMC_ROTLW = 4'h6,
    RMC_SLWI = 4'h7,
    RMC_SRWI = 4'h8,
    RMC_CLRL = 4'h9,
    RMC_CLRR = 4'ha,
    RMC_CLRLSL = 4'hb,
    RMC_CMP = 4'hc,
    RMC_CMPL = 4'hd,
    RMC_CRLOG = 4'he
  } rmc_op_t;

  typedef enum logic [1:0] {
    RMC_CR_EQV = 2'h0,
    RMC_CR_XOR = 2'h1,
    RMC_CR_OR = 2'h2,
    RMC_CR_NOR = 2'h3
  } rmc_crfunc_t;

  // ==========================================================
  // Request bundle
  typedef struct packed {
    rmc_op_t op;
    logic record;
    logic size_sel;
    logic use_imm;
    logic [2:0] target_flag_field;
    logic [`RMC_IMMW-1:0] imm;
    logic [`RMC_CNTW-1:0] n;
    logic [`RMC_SHW-1:0] b;
    rmc_crfunc_t crfunc;
    logic [4:0] bit_t;
    logic [4:0] bit_a;
    logic [4:0] bit_b;
  } rmc_req_t;

endpackage

// [design/rmc_rotmask.sv]
/*
  Rotate-left and mask datapath, combinational.
  Bit 0 is the most significant bit in mask bounds.
*/
`timescale 1ns/1ps
`default_nettype none

module rmc_rotmask #(
  parameter int XLEN = 32
) (
  // Operands
  input wire logic [XLEN-1:0] src_in,
  input wire logic [XLEN-1:0] old_in,
  // Controls
  input wire logic [4:0] sh_in,
  input wire logic [4:0] mb_in,
  input wire logic [4:0] me_in,
  input wire logic insert_in,
  // Result
  output logic [XLEN-1:0] result_out,
  output logic [XLEN-1:0] mask_out
);

  logic [2*XLEN-1:0] dbl;
  logic [XLEN-1:0] rot;

  assign dbl = {src_in, src_in} << sh_in;
  assign rot = dbl[2*XLEN-1:XLEN];

  // ==========================================================
  // Mask, wrapping when start lies past end
  genvar gi;
  generate
    for (gi = 0; gi < XLEN; gi++) begin : g_mask
      localparam logic [4:0] POS = 5'(XLEN - 1 - gi);
      assign mask_out[gi] = (mb_in <= me_in) ?
        (POS >= mb_in && POS <= me_in) : (POS >= mb_in || POS <= me_in);
    end
  endgenerate

  assign result_out = (rot & mask_out) |
                      (insert_in ? (old_in & ~mask_out) : '0);

endmodule

`default_nettype wire

// [design/rmc_unit.sv]
/*
  Rotate, mask and compare unit: word compares into a chosen condition
  field, single condition-bit logic, and rotate-with-mask operations.
  Assumes the decoder presents one request per valid cycle with operands.
*/
// How it works
// (RL1) Only 32-bit word compares exist
// (RL2) Size select must be zero for compares
// (RL3) Compare writes the selected condition field
// (RL4) Signed and unsigned, register or immediate
// (RL5) Set, clear, copy, invert one condition bit
// (RL6) Extract n bits at b, justify, zero rest
// (RL7) Insert n bits at b, keep others
// (RL8) Rotate left or right, full mask
// (RL9) Logical shift by n below 32
// (RL10) Clear leftmost or rightmost n bits
// (RL11) Clear left b then shift left n
// (RL12) Rotate left by third register amount
// (RL13) Record form updates first result field
// (RL14) Bit ops via eqv, xor, or, nor
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.svh"

module rmc_unit
  import rmc_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Request
  input wire logic req_valid_in,
  input wire rmc_req_t req_in,
  input wire logic [`RMC_XLEN-1:0] rs_in,
  input wire logic [`RMC_XLEN-1:0] rb_in,
  input wire logic [`RMC_XLEN-1:0] ra_old_in,
  input wire logic so_in,
  // Answer
  output logic done_out,
  output logic illegal_out,
  output logic [`RMC_XLEN-1:0] result_out,
  output logic [`RMC_XLEN-1:0] cr_out
);

  localparam logic [5:0] W = `RMC_WORD_BITS;
  localparam logic [5:0] L = `RMC_LAST_BIT;

  // Vector index of a condition bit numbered from the left
  function automatic logic [4:0] cr_idx(input logic [4:0] pos);
    cr_idx = ~pos;
  endfunction

  logic [5:0] n;
  logic [5:0] b;
  logic [5:0] sh6;
  logic [5:0] mb6;
  logic [5:0] me6;
  logic ins;
  logic bad;
  logic is_rot;
  logic is_cmp;
  logic [`RMC_XLEN-1:0] rm_res;
  logic [`RMC_XLEN-1:0] opb;
  logic lt;
  logic gt;
  logic eq;
  logic [4:0] lt_idx;
  logic [4:0] gt_idx;
  logic [4:0] eq_idx;
  logic [4:0] so_idx;
  logic crbit;
  logic [`RMC_XLEN-1:0] next_cr;

  assign n = req_in.n;
  assign b = {1'b0, req_in.b};
  assign is_cmp = req_in.op == RMC_CMP || req_in.op == RMC_CMPL;
  assign is_rot = !is_cmp && req_in.op != RMC_CRLOG;

  // ==========================================================
  // Rotate amount and mask bounds per operation
  always_comb begin
    sh6 = 6'h0;
    mb6 = 6'h0;
    me6 = L;
    ins = 1'b0;
    bad = 1'b0;
    unique case (req_in.op)
      RMC_EXTL: begin // see (RL6)
        sh6 = b;
        me6 = n - 6'h1;
        bad = n == 6'h0 || n > W;
      end
      RMC_EXTR: begin // see (RL6)
        sh6 = b + n;
        mb6 = W - n;
        bad = n == 6'h0 || n > W;
      end
      RMC_INSL: begin // see (RL7)
        sh6 = W - b;
        mb6 = b;
        me6 = b + n - 6'h1;
        ins = 1'b1;
        bad = n == 6'h0 || n > W;
      end
      RMC_INSR: begin // see (RL7)
        sh6 = W - (b + n);
        mb6 = b;
        me6 = b + n - 6'h1;
        ins = 1'b1;
        bad = n == 6'h0 || n > W;
      end
      RMC_ROTLI: begin // see (RL8)
        sh6 = n;
        bad = n > L;
      end
      RMC_ROTRI: begin // see (RL8)
        sh6 = W - n;
        bad = n > L;
      end
      RMC_ROTLW: begin // see (RL12)
        sh6 = {1'b0, rb_in[4:0]};
      end
      RMC_SLWI: begin // see (RL9)
        sh6 = n;
        me6 = L - n;
        bad = n > L;
      end
      RMC_SRWI: begin // see (RL9)
        sh6 = W - n;
        mb6 = n;
        bad = n > L;
      end
      RMC_CLRL: begin // see (RL10)
        mb6 = n;
        bad = n > L;
      end
      RMC_CLRR: begin // see (RL10)
        me6 = L - n;
        bad = n > L;
      end
      RMC_CLRLSL: begin // see (RL11)
        sh6 = n;
        mb6 = b - n;
        me6 = L - n;
        bad = n > b;
      end
      RMC_CMP, RMC_CMPL: begin
        bad = req_in.size_sel != `RMC_WORD_SIZE; // see (RL1) (RL2)
      end
      RMC_CRLOG: begin
        bad = 1'b0;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  rmc_rotmask #(
    .XLEN(`RMC_XLEN)
  ) u_rotmask (
    .src_in(rs_in),
    .old_in(ra_old_in),
    .sh_in(sh6[4:0]),
    .mb_in(mb6[4:0]),
    .me_in(me6[4:0]),
    .insert_in(ins),
    .result_out(rm_res),
    .mask_out()
  );

  // ==========================================================
  // Compare; second operand from register or extended immediate
  always_comb begin
    if (!req_in.use_imm) begin // see (RL4)
      opb = rb_in;
    end else if (req_in.op == RMC_CMPL) begin
      opb = {{(`RMC_XLEN-`RMC_IMMW){1'b0}}, req_in.imm};
    end else begin
      opb = {{(`RMC_XLEN-`RMC_IMMW){req_in.imm[`RMC_IMMW-1]}}, req_in.imm};
    end
  end

  // Word-only compare; no doubleword path is built, see (RL1)
  assign lt = (req_in.op == RMC_CMPL) ? rs_in < opb :
              $signed(rs_in) < $signed(opb);
  assign gt = (req_in.op == RMC_CMPL) ? rs_in > opb :
              $signed(rs_in) > $signed(opb);
  assign eq = rs_in == opb;

  assign lt_idx = cr_idx({req_in.target_flag_field, `RMC_FLD_LT});
  assign gt_idx = cr_idx({req_in.target_flag_field, `RMC_FLD_GT});
  assign eq_idx = cr_idx({req_in.target_flag_field, `RMC_FLD_EQ});
  assign so_idx = cr_idx({req_in.target_flag_field, `RMC_FLD_SO});

  // Set and clear come as eqv and xor of a bit with itself, see (RL14)
  always_comb begin
    unique case (req_in.crfunc)
      RMC_CR_EQV: crbit = ~(cr_out[cr_idx(req_in.bit_a)] ^
                            cr_out[cr_idx(req_in.bit_b)]);
      RMC_CR_XOR: crbit = cr_out[cr_idx(req_in.bit_a)] ^
                          cr_out[cr_idx(req_in.bit_b)];
      RMC_CR_OR: crbit = cr_out[cr_idx(req_in.bit_a)] |
                         cr_out[cr_idx(req_in.bit_b)];
      RMC_CR_NOR: crbit = ~(cr_out[cr_idx(req_in.bit_a)] |
                            cr_out[cr_idx(req_in.bit_b)]);
    endcase
  end

  // ==========================================================
  // Next condition register
  always_comb begin
    next_cr = cr_out;
    if (is_cmp) begin // see (RL3)
      next_cr[lt_idx] = lt;
      next_cr[gt_idx] = gt;
      next_cr[eq_idx] = eq;
      next_cr[so_idx] = so_in;
    end else if (req_in.op == RMC_CRLOG) begin
      next_cr[cr_idx(req_in.bit_t)] = crbit; // see (RL5)
    end else if (req_in.record) begin // see (RL13)
      next_cr[cr_idx({`RMC_FIRST_RESULT_FIELD, `RMC_FLD_LT})] =
        rm_res[`RMC_XLEN-1];
      next_cr[cr_idx({`RMC_FIRST_RESULT_FIELD, `RMC_FLD_GT})] =
        !rm_res[`RMC_XLEN-1] && rm_res != '0;
      next_cr[cr_idx({`RMC_FIRST_RESULT_FIELD, `RMC_FLD_EQ})] =
        rm_res == '0;
      next_cr[cr_idx({`RMC_FIRST_RESULT_FIELD, `RMC_FLD_SO})] = so_in;
    end
  end

  // ==========================================================
  // Registers; refused requests leave cr_out and result_out unchanged and only raise illegal_out
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cr_out <= `RMC_CR_RESET;
    end else if (req_valid_in && !bad) begin
      cr_out <= next_cr;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result_out <= `RMC_RESULT_RESET;
    end else if (req_valid_in && !bad && is_rot) begin
      result_out <= rm_res;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_out <= 1'b0;
      illegal_out <= 1'b0;
    end else begin
      done_out <= req_valid_in && !bad;
      illegal_out <= req_valid_in && bad;
    end
  end

  // ==========================================================
  // Checks
  sequence s_cmp_taken;
    req_valid_in && is_cmp && req_in.size_sel == `RMC_WORD_SIZE;
  endsequence

  property p_cmp_size;
    @(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && is_cmp && req_in.size_sel != `RMC_WORD_SIZE |=>
        illegal_out && !done_out && $stable(cr_out);
  endproperty
  a_cmp_size: assert property (p_cmp_size) // see (RL1) (RL2)
    else $error("sized compare not refused");

  property p_cmp_field;
    @(posedge clock_in) disable iff (!rst_b_in)
      s_cmp_taken |=> done_out && cr_out[$past(eq_idx)] == $past(eq) &&
        cr_out[$past(so_idx)] == $past(so_in);
  endproperty
  a_cmp_field: assert property (p_cmp_field) // see (RL3)
    else $error("compare field not written");

  property p_cmp_order;
    @(posedge clock_in) disable iff (!rst_b_in)
      s_cmp_taken ##0 (req_in.op == RMC_CMPL) |=>
        cr_out[$past(gt_idx)] == ($past(rs_in) > $past(opb)) &&
        cr_out[$past(lt_idx)] == ($past(rs_in) < $past(opb));
  endproperty
  a_cmp_order: assert property (p_cmp_order) // see (RL4)
    else $error("unsigned compare wrong");

  property p_cr_set;
    @(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && req_in.op == RMC_CRLOG &&
      req_in.bit_a == req_in.bit_b |=>
        cr_out[cr_idx($past(req_in.bit_t))] ==
          ($past(req_in.crfunc) == RMC_CR_EQV ? 1'b1 :
           $past(req_in.crfunc) == RMC_CR_XOR ? 1'b0 :
           $past(req_in.crfunc) == RMC_CR_OR ?
             $past(cr_out[cr_idx(req_in.bit_a)]) :
             !$past(cr_out[cr_idx(req_in.bit_a)]));
  endproperty
  a_cr_set: assert property (p_cr_set) // see (RL5) (RL14)
    else $error("condition bit op wrong");

  property p_ext_zero;
    @(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && req_in.op == RMC_EXTL && n == 6'h0 |=>
        illegal_out ##1 !illegal_out || $past(req_valid_in);
  endproperty
  a_ext_zero: assert property (p_ext_zero) // see (RL6)
    else $error("empty extract accepted");

  property p_shift;
    @(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && n < W && (req_in.op == RMC_SRWI ||
      req_in.op == RMC_SLWI) |=> done_out && result_out ==
        ($past(req_in.op) == RMC_SRWI ? $past(rs_in) >> $past(n) :
         $past(rs_in) << $past(n));
  endproperty
  a_shift: assert property (p_shift) // see (RL9)
    else $error("logical shift wrong");

  property p_clrl;
    @(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && req_in.op == RMC_CLRL && n < W |=>
        result_out == ($past(rs_in) & ({`RMC_XLEN{1'b1}} >> $past(n)));
  endproperty
  a_clrl: assert property (p_clrl) // see (RL10)
    else $error("clear left wrong");

  property p_rotlw;
    @(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && req_in.op == RMC_ROTLW |=>
        result_out == (($past(rs_in) << $past(rb_in[4:0])) |
          ($past(rs_in) >> (W - $past({1'b0, rb_in[4:0]}))));
  endproperty
  a_rotlw: assert property (p_rotlw) // see (RL12)
    else $error("variable rotate wrong");

  property p_record;
    @(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && is_rot && !bad && req_in.record |=>
        cr_out[31:28] == {$signed(result_out) < 0,
          $signed(result_out) > 0, result_out == '0, $past(so_in)};
  endproperty
  a_record: assert property (p_record) // see (RL13)
    else $error("record field wrong");

endmodule

`default_nettype wire

// [dv/rmc_dec_model.sv]
/*
  Decoder and register file stand-in that presents requests to the unit.
  Assumes the caller is at a falling clock edge when it calls a task.
*/
`timescale 1ns/1ps
`default_nettype none

module rmc_dec_model
  import rmc_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Request to the unit
  output logic valid_out,
  output rmc_req_t req_out,
  output logic [31:0] rs_out,
  output logic [31:0] rb_out,
  output logic [31:0] old_out,
  output logic so_out
);
  // ==========================================================
  // Drive
  initial begin
    valid_out = 1'b0;
    req_out = '0;
    rs_out = 32'h0;
    rb_out = 32'h0;
    old_out = 32'h0;
    so_out = 1'b0;
  end

  task automatic send(input rmc_req_t r, input logic [31:0] a, bv, o,
                      input logic so);
    valid_out = 1'b1;
    req_out = r;
    rs_out = a;
    rb_out = bv;
    old_out = o;
    so_out = so;
    @(negedge clock_in);
  endtask

  // Idle request and operand lines flip, so_out holds, so stale operands never look valid
  task automatic idle();
    valid_out = 1'b0;
    req_out = rmc_req_t'(~req_out);
    rs_out = ~rs_out;
    rb_out = ~rb_out;
    old_out = ~old_out;
    @(negedge clock_in);
  endtask
endmodule

`default_nettype wire

// [dv/rotate_mask_compare_unit_tb_top.sv]
/*
  Self-checking bench for the rotate, mask and compare unit.
  Assumes the package and the decoder model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module rotate_mask_compare_unit_tb_top
  import rmc_pkg::*;
;
  // ==========================================================
  // Signals
  logic clock_in, rst_b_in, valid, so, done, illegal, so_v;
  rmc_req_t req;
  logic [31:0] rs, rb, old, result, cr, res_exp, cr_exp;
  int n_fail, comparisons, cycles;

  rmc_dec_model dec(.clock_in(clock_in), .valid_out(valid), .req_out(req),
    .rs_out(rs), .rb_out(rb), .old_out(old), .so_out(so));
  rmc_unit dut(.clock_in(clock_in), .rst_b_in(rst_b_in),
    .req_valid_in(valid), .req_in(req), .rs_in(rs), .rb_in(rb),
    .ra_old_in(old), .so_in(so), .done_out(done), .illegal_out(illegal),
    .result_out(result), .cr_out(cr));

  always #20 clock_in = ~clock_in;

  // Cut short a hang
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      test_done();
    end
  end

  // ==========================================================
  // Helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] rl(input logic [31:0] x, input int s);
    s = s % 32;
    return (x << s) | (x >> (32 - s));
  endfunction

  // Mask from bit mb to me, bit 0 leftmost
  function automatic logic [31:0] mk(input int mb, me);
    return (32'hffffffff >> mb) & ~(32'hffffffff >> (me + 1));
  endfunction

  function automatic logic [31:0] rm(input rmc_op_t op, input int n, b,
                                     input logic [31:0] s, bv, o);
    logic [31:0] m;
    m = mk(b, b + n - 1);
    case (op)
      RMC_EXTL: return (s << b) & ~(32'hffffffff >> n);
      RMC_EXTR: return (s >> (32 - b - n)) & ~(32'hffffffff << n);
      RMC_INSL: return (rl(s, 32 - b) & m) | (o & ~m);
      RMC_INSR: return (rl(s, 64 - b - n) & m) | (o & ~m);
      RMC_ROTLI: return rl(s, n);
      RMC_ROTRI: return rl(s, 32 - n);
      RMC_ROTLW: return rl(s, int'(bv[4:0]));
      RMC_SLWI: return s << n;
      RMC_SRWI: return s >> n;
      RMC_CLRL: return s & (32'hffffffff >> n);
      RMC_CLRR: return s & (32'hffffffff << n);
      default: return (s & (32'hffffffff >> b)) << n;
    endcase
  endfunction

  function automatic rmc_req_t rq(input logic [3:0] op, input logic [5:0] n,
                                  input logic [4:0] b, input logic sz);
    rmc_req_t r;
    r = '0;
    r.op = rmc_op_t'(op);
    r.n = n;
    r.b = b;
    r.size_sel = sz;
    return r;
  endfunction

  task automatic run(input rmc_req_t r, input logic [31:0] a, bv, o,
                     input logic ok);
    dec.send(r, a, bv, o, so_v);
    chk("done", done, ok);
    chk("illegal", illegal, !ok);
    chk("result", result, res_exp);
    chk("cr", cr, cr_exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_rm(input rmc_op_t op, input logic [5:0] n,
                      input logic [4:0] b, input logic [31:0] a, bv, o,
                      input logic rec);
    rmc_req_t r;
    r = rq(op, n, b, 1'b0);
    r.record = rec;
    res_exp = rm(op, n, b, a, bv, o);
    if (rec) cr_exp[31:28] = {$signed(res_exp) < 0, $signed(res_exp) > 0,
                              res_exp == 32'h0, so_v};
    run(r, a, bv, o, 1'b1);
  endtask

  task automatic t_cmp(input rmc_op_t op, input logic [2:0] tf,
                       input logic ui, input logic [31:0] a, bv,
                       input logic [15:0] im);
    rmc_req_t r;
    logic [31:0] y;
    logic lt, gt;
    r = rq(op, 6'h0, 5'h0, 1'b0);
    r.target_flag_field = tf;
    r.use_imm = ui;
    r.imm = im;
    y = !ui ? bv : (op == RMC_CMP) ? {{16{im[15]}}, im} : {16'h0, im};
    lt = (op == RMC_CMP) ? $signed(a) < $signed(y) : a < y;
    gt = (op == RMC_CMP) ? $signed(a) > $signed(y) : a > y;
    cr_exp[31 - 4 * tf -: 4] = {lt, gt, a == y, so_v};
    run(r, a, bv, 32'h0, 1'b1);
  endtask

  task automatic t_cr(input rmc_crfunc_t f, input logic [4:0] bt, ba, bb);
    rmc_req_t r;
    logic x, y;
    r = rq(RMC_CRLOG, 6'h0, 5'h0, 1'b0);
    r.crfunc = f;
    r.bit_t = bt;
    r.bit_a = ba;
    r.bit_b = bb;
    x = cr_exp[31 - ba];
    y = cr_exp[31 - bb];
    case (f)
      RMC_CR_EQV: cr_exp[31 - bt] = ~(x ^ y);
      RMC_CR_XOR: cr_exp[31 - bt] = x ^ y;
      RMC_CR_OR: cr_exp[31 - bt] = x | y;
      default: cr_exp[31 - bt] = ~(x | y);
    endcase
    run(r, 32'h0, 32'h0, 32'h0, 1'b1);
  endtask

  // Refused: illegal rises, result and cr may not change
  task automatic t_bad(input logic [3:0] op, input logic [5:0] n,
                       input logic [4:0] b, input logic sz);
    run(rq(op, n, b, sz), 32'h5a5a5a5a, 32'h1, 32'h0, 1'b0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clock_in = 1'b0;
    rst_b_in = 1'b0;
    so_v = 1'b0;
    res_exp = 32'h0;
    cr_exp = 32'h0;
    repeat (4) @(negedge clock_in);
    chk("reset result", result, 32'h0);
    chk("reset cr", cr, 32'h0);
    chk("reset done", done, 32'h0);
    chk("reset illegal", illegal, 32'h0);
    rst_b_in = 1'b1;
    t_rm(RMC_SRWI, 6'h4, 5'h0, 32'hf0, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_SLWI, 6'h1f, 5'h0, 32'h3, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_EXTL, 6'h8, 5'h4, 32'h12345678, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_EXTL, 6'h20, 5'h0, 32'h89abcdef, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_EXTR, 6'h1, 5'h1f, 32'h1, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_EXTR, 6'hc, 5'h8, 32'h12345678, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_INSL, 6'h4, 5'h1c, 32'ha0000000, 32'h0, 32'hffffffff,
         1'b0);
    t_rm(RMC_INSR, 6'h8, 5'h0, 32'h000000c3, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_INSR, 6'h3, 5'h14, 32'h5, 32'h0, 32'h12345678, 1'b0);
    t_rm(RMC_ROTLI, 6'h1f, 5'h0, 32'h80000001, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_ROTRI, 6'h0, 5'h0, 32'hdeadbeef, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_ROTRI, 6'h1, 5'h0, 32'h00000003, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_ROTLW, 6'h0, 5'h0, 32'h12345678, 32'hffffffe5, 32'h0,
         1'b0);
    t_rm(RMC_CLRL, 6'h0, 5'h0, 32'hffffffff, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_CLRL, 6'h1f, 5'h0, 32'hffffffff, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_CLRR, 6'h1f, 5'h0, 32'hffffffff, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_CLRLSL, 6'h2, 5'h8, 32'hffffffff, 32'h0, 32'h0, 1'b0);
    t_rm(RMC_CLRLSL, 6'h1f, 5'h1f, 32'hffffffff, 32'h0, 32'h0,
         1'b0);
    so_v = 1'b1;
    t_rm(RMC_SLWI, 6'h1f, 5'h0, 32'h1, 32'h0, 32'h0, 1'b1);
    t_rm(RMC_EXTR, 6'h4, 5'h0, 32'h70000000, 32'h0, 32'h0, 1'b1);
    so_v = 1'b0;
    t_rm(RMC_CLRL, 6'h1f, 5'h0, 32'h0, 32'h0, 32'h0, 1'b1);
    t_cmp(RMC_CMP, 3'h2, 1'b0, 32'h5, 32'h5, 16'h0);
    t_cmp(RMC_CMP, 3'h7, 1'b0, 32'hffffffff, 32'h1, 16'h0);
    t_cmp(RMC_CMPL, 3'h7, 1'b0, 32'hffffffff, 32'h1, 16'h0);
    t_cmp(RMC_CMP, 3'h0, 1'b1, 32'hfffffffe, 32'h0, 16'hfffe);
    t_cmp(RMC_CMPL, 3'h0, 1'b1, 32'hfffffffe, 32'h0, 16'hfffe);
    so_v = 1'b1;
    t_cmp(RMC_CMP, 3'h3, 1'b0, 32'h80000000, 32'h0, 16'h0);
    t_cr(RMC_CR_EQV, 5'h5, 5'h5, 5'h5);
    t_cr(RMC_CR_XOR, 5'h1, 5'h1, 5'h1);
    t_cr(RMC_CR_OR, 5'h9, 5'ha, 5'ha);
    t_cr(RMC_CR_NOR, 5'h1e, 5'h1f, 5'h1f);
    t_cr(RMC_CR_XOR, 5'h1, 5'ha, 5'h1f);
    t_bad(RMC_CMP, 6'h0, 5'h0, 1'b1);
    t_bad(RMC_EXTL, 6'h0, 5'h0, 1'b0);
    t_bad(RMC_INSR, 6'h21, 5'h0, 1'b0);
    t_bad(RMC_ROTLI, 6'h20, 5'h0, 1'b0);
    t_bad(RMC_SRWI, 6'h20, 5'h0, 1'b0);
    t_bad(RMC_CLRR, 6'h20, 5'h0, 1'b0);
    t_bad(RMC_CLRLSL, 6'h4, 5'h3, 1'b0);
    t_bad(4'hf, 6'h0, 5'h0, 1'b0);
    dec.idle();
    chk("done idle", done, 1'b0);
    chk("illegal idle", illegal, 1'b0);
    // Second reset in mid-run
    rst_b_in = 1'b0;
    @(negedge clock_in);
    res_exp = 32'h0;
    cr_exp = 32'h0;
    chk("rerun cr", cr, 32'h0);
    chk("rerun result", result, 32'h0);
    rst_b_in = 1'b1;
    t_rm(RMC_ROTLI, 6'h4, 5'h0, 32'h12345678, 32'h0, 32'h0, 1'b1);
    dec.idle();
    test_done();
  end
endmodule

`default_nettype wire
